// [core/safety_stop_supervisor.v]
// Stop supervisor: torque cut-off, ramped and emergency stops, brake timing, speed trips, mute window
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "stop_supervisor_defs.vh"
// Functional notes
// RL1: While the mute window runs, speed limit checks are suspended.
// RL2: Mute applies to estimated speed and to encoder speed alike.
// RL3: One global mute duration by default; per-function duration when selected.
// RL4: Reaction time to a limit hit grows by the mute duration.
// RL5: Torque cut-off opens the drive circuit, motor coasts (category 0).
// RL6: Ramp monitor violation or timed-stop overrun triggers torque cut-off.
// RL7: Internal failure triggers torque cut-off and the brake output.
// RL8: Controlled ramp stop to zero, supervised by time or ramp shape.
// RL9: Emergency stop is immediate cut-off or supervised emergency ramp.
// RL10: Internal faults also start the emergency stop.
// RL11: Brake output coupled to cut-off: before, with, or after it.
// RL12: Ramped stop reaching zero speed asserts cut-off and brake.
// RL13: Limited-speed or max-speed trip launches the emergency stop.
// RL14: Brake and cut-off optionally triggered at a falling speed threshold.
// RL15: With a delay, brake asserts at threshold, cut-off after the delay.
// RL16: Safety controller may scale limited-speed limits down; device applies them.
// RL17: Max-speed guard is a static enable, not a request.
// RL18: Restart inhibit holds torque cut-off asserted.
// RL19: Emergency ramp monitor for emergency stop; general monitor for the rest.
// RL20: Drive speed versus own speed too far apart enters fail-safe; compared only while the estimated speed is the source, not with encoder source.
// RL21: Mute is a counter started at a limit hit, expiry resumes checks.
module safety_stop_supervisor #(
    parameter SPEED_W = 16,
    parameter TIME_W  = 24
) (
    input  wire                clk_sys,
    input  wire                rst_n,
    input  wire [31:0]         s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output reg                 s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output reg                 s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [31:0]         s_axi_araddr,
    input  wire                s_axi_arvalid,
    output reg                 s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    input  wire [SPEED_W-1:0]  speed_est,
    input  wire [SPEED_W-1:0]  speed_drive,
    input  wire [SPEED_W-1:0]  speed_enc,
    input  wire [7:0]          lim_scale,
    input  wire                internal_fault,
    output reg                 torque_cutoff,
    output reg                 brake_output
);
    localparam [2:0] ST_RUN   = 3'h0;
    localparam [2:0] ST_RAMP  = 3'h1;
    localparam [2:0] ST_BRAKE = 3'h2;
    localparam [2:0] ST_CUT   = 3'h3;
    localparam integer      LAG_CYCLES = `BRAKE_LAG_US * `CLK_MHZ;
    localparam [TIME_W-1:0] BRAKE_LAG  = LAG_CYCLES[TIME_W-1:0];

    // Pin inputs pass two flops
    reg [SPEED_W-1:0] est_s1, est_s2, drv_s1, drv_s2, enc_s1, enc_s2;
    reg [7:0]         scale_s1, scale_s2;
    reg [1:0]         fault_sync;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            est_s1 <= {SPEED_W{1'b0}};
            est_s2 <= {SPEED_W{1'b0}};
            drv_s1 <= {SPEED_W{1'b0}};
            drv_s2 <= {SPEED_W{1'b0}};
            enc_s1 <= {SPEED_W{1'b0}};
            enc_s2 <= {SPEED_W{1'b0}};
            scale_s1 <= 8'hff;
            scale_s2 <= 8'hff;
            fault_sync <= 2'h0;
        end else begin
            est_s1 <= speed_est;
            est_s2 <= est_s1;
            drv_s1 <= speed_drive;
            drv_s2 <= drv_s1;
            enc_s1 <= speed_enc;
            enc_s2 <= enc_s1;
            scale_s1 <= lim_scale;
            scale_s2 <= scale_s1;
            fault_sync <= {fault_sync[0], internal_fault};
        end
    end

    // Registers
    reg [5:0]         ctrl;
    reg [8:0]         cfg;
    reg [TIME_W-1:0]  mute_global, mute_fn, brake_delay, stop_time;
    reg [SPEED_W-1:0] lim_speed, max_speed, brake_speed, ramp0, ramp1, diff_limit;
    reg [2:0]         state;
    reg [TIME_W-1:0]  stop_cnt, brake_cnt, mute_cnt;
    reg [SPEED_W-1:0] ramp_env;
    reg               in_estop, failsafe, muted;

    function [SPEED_W-1:0] absdiff;
        input [SPEED_W-1:0] a;
        input [SPEED_W-1:0] b;
        begin
            absdiff = (a > b) ? a - b : b - a;
        end
    endfunction

    // AXI4-Lite write: address and data in either order
    reg        aw_held, w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    // A second write waits until the response has been taken
    wire       wr_go = aw_held && w_held && !s_axi_bvalid;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            ctrl <= 6'h00;
            cfg <= `CFG_RESET_VAL;
            mute_global <= {TIME_W{1'b0}};
            mute_fn <= {TIME_W{1'b0}};
            brake_delay <= {TIME_W{1'b0}};
            stop_time <= {TIME_W{1'b1}};
            lim_speed <= {SPEED_W{1'b1}};
            max_speed <= {SPEED_W{1'b1}};
            brake_speed <= {SPEED_W{1'b0}};
            ramp0 <= {SPEED_W{1'b0}};
            ramp1 <= {SPEED_W{1'b0}};
            diff_limit <= {SPEED_W{1'b1}};
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            ctrl[`CTRL_CLEAR] <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_addr)
                `REG_CTRL:        ctrl <= w_data[5:0];
                `REG_CFG:         cfg <= w_data[8:0];
                `REG_MUTE_GLOBAL: mute_global <= w_data[TIME_W-1:0];
                `REG_MUTE_FN:     mute_fn <= w_data[TIME_W-1:0];
                `REG_LIM_SPEED:   lim_speed <= w_data[SPEED_W-1:0];
                `REG_MAX_SPEED:   max_speed <= w_data[SPEED_W-1:0];
                `REG_BRAKE_SPEED: brake_speed <= w_data[SPEED_W-1:0];
                `REG_BRAKE_DELAY: brake_delay <= w_data[TIME_W-1:0];
                `REG_STOP_TIME:   stop_time <= w_data[TIME_W-1:0];
                `REG_RAMP0:       ramp0 <= w_data[SPEED_W-1:0];
                `REG_RAMP1:       ramp1 <= w_data[SPEED_W-1:0];
                `REG_DIFF_LIMIT:  diff_limit <= w_data[SPEED_W-1:0];
                default:          s_axi_bresp <= 2'h2;
                endcase
            end
        end
    end

    // Speed source and limits
    wire [SPEED_W-1:0] speed = cfg[`CFG_ENCODER_SRC] ? enc_s2 : est_s2; // see RL2
    // Scale 255 leaves the limit just under its full value
    wire [SPEED_W+7:0] scaled_full = lim_speed * scale_s2;
    wire [SPEED_W-1:0] lim_eff = scaled_full[SPEED_W+7:8]; // see RL16
    wire lim_hit = ctrl[`CTRL_LIM_SPEED] && (speed >= lim_eff); // see RL13
    wire max_hit = cfg[`CFG_MAX_GUARD_EN] && (speed >= max_speed); // see RL17
    wire raw_hit = lim_hit || max_hit;
    // Per-function duration replaces the global one, it never adds
    wire [TIME_W-1:0] mute_len = cfg[`CFG_PER_FN_MUTE] ? mute_fn : mute_global; // see RL3
    // Mute counter starts at first hit; a persisting hit trips after it expires
    wire mute_done = muted && (mute_cnt == {TIME_W{1'b0}});
    wire speed_trip = raw_hit && (mute_len == {TIME_W{1'b0}} || mute_done); // see RL4
    wire mismatch = !cfg[`CFG_ENCODER_SRC] && (absdiff(est_s2, drv_s2) > diff_limit); // see RL20
    wire fault = fault_sync[1] || failsafe; // see RL7
    wire estop_req = ctrl[`CTRL_ESTOP] || fault || speed_trip; // see RL10
    wire ramp_req = ctrl[`CTRL_RAMP_STOP];
    wire immed_cut = ctrl[`CTRL_TORQUE_CUT] || ctrl[`CTRL_RESTART_INH] || fault
                     || (estop_req && cfg[`CFG_ESTOP_IMMED]); // see RL5 see RL9 see RL18
    wire ramp_type = in_estop ? cfg[`CFG_ESTOP_TYPE] : cfg[`CFG_RAMP_STOP_TYPE]; // see RL8
    wire [SPEED_W-1:0] ramp_rate = in_estop ? ramp0 : ramp1; // see RL19
    wire ramp_bad = ramp_type ? (speed > ramp_env) : (stop_cnt >= stop_time); // see RL6
    wire [1:0] border = cfg[`CFG_BRAKE_ORDER_HI:`CFG_BRAKE_ORDER_LO];
    wire at_thresh = cfg[`CFG_BRAKE_AT_SPEED] ? (speed <= brake_speed) : (speed == {SPEED_W{1'b0}});

    // Mute window counter
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            muted <= 1'b0;
            mute_cnt <= {TIME_W{1'b0}};
            failsafe <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            // A latched fail-safe needs a clear of its own before the cut state is left
            if (mismatch)
                failsafe <= 1'b1;
            else if (ctrl[`CTRL_CLEAR] && !fault_sync[1])
                failsafe <= 1'b0;
            if (!raw_hit) begin
                muted <= 1'b0; // see RL21
            end else if (!muted && mute_len != {TIME_W{1'b0}}) begin
                muted <= 1'b1; // see RL1 see RL21
                mute_cnt <= mute_len - 1'b1;
            end else if (muted && mute_cnt != {TIME_W{1'b0}}) begin
                mute_cnt <= mute_cnt - 1'b1;
            end
        end
    end

    // Stop sequencer
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
            in_estop <= 1'b0;
            stop_cnt <= {TIME_W{1'b0}};
            brake_cnt <= {TIME_W{1'b0}};
            ramp_env <= {SPEED_W{1'b0}};
            torque_cutoff <= 1'b0;
            brake_output <= 1'b0;
        end else begin
            case (state)
            ST_RUN: begin
                brake_output <= 1'b0;
                torque_cutoff <= 1'b0;
                // Counter acts one edge after reaching zero, so load one less
                brake_cnt <= BRAKE_LAG - 1'b1;
                if (immed_cut) begin
                    // Fault path follows the brake order as well
                    state <= ST_CUT; // see RL11
                    in_estop <= estop_req; // see RL10
                    torque_cutoff <= (border != `BRAKE_BEFORE);
                    brake_output <= (border != `BRAKE_AFTER);
                end else if (estop_req || ramp_req) begin
                    state <= ST_RAMP; // see RL13
                    in_estop <= estop_req;
                    stop_cnt <= {TIME_W{1'b0}};
                    ramp_env <= speed;
                end
            end
            ST_RAMP: begin
                if (estop_req)
                    in_estop <= 1'b1;
                stop_cnt <= stop_cnt + 1'b1;
                ramp_env <= (ramp_env > ramp_rate) ? ramp_env - ramp_rate : {SPEED_W{1'b0}};
                brake_cnt <= brake_delay;
                if (immed_cut || ramp_bad) begin
                    state <= ST_CUT; // see RL6
                    torque_cutoff <= 1'b1;
                    brake_output <= 1'b1;
                end else if (at_thresh) begin
                    brake_output <= 1'b1; // see RL12 see RL14
                    if (brake_delay == {TIME_W{1'b0}}) begin
                        torque_cutoff <= 1'b1;
                        state <= ST_CUT;
                    end else begin
                        state <= ST_BRAKE; // see RL15
                    end
                end
            end
            ST_BRAKE: begin
                brake_cnt <= brake_cnt - 1'b1;
                if (brake_cnt <= {{(TIME_W-1){1'b0}}, 1'b1} || immed_cut) begin
                    torque_cutoff <= 1'b1; // see RL15
                    state <= ST_CUT;
                end
            end
            ST_CUT: begin
                // Lagging output follows after the fixed lag
                if (brake_cnt != {TIME_W{1'b0}})
                    brake_cnt <= brake_cnt - 1'b1;
                else begin
                    torque_cutoff <= 1'b1;
                    brake_output <= 1'b1; // see RL11
                end
                // Leaves only on explicit clear with no request pending
                if (ctrl[`CTRL_CLEAR] && !immed_cut && !estop_req && !ramp_req && !raw_hit) begin
                    state <= ST_RUN;
                    in_estop <= 1'b0;
                end
            end
            default: state <= ST_RUN;
            endcase
        end
    end

    // AXI4-Lite read, one cycle after address accepted
    reg [31:0] rd_mux;
    always @* begin
        case (s_axi_araddr[7:0])
        `REG_CTRL:        rd_mux = {26'h0, ctrl};
        `REG_CFG:         rd_mux = {23'h0, cfg};
        `REG_MUTE_GLOBAL: rd_mux = {{(32-TIME_W){1'b0}}, mute_global};
        `REG_MUTE_FN:     rd_mux = {{(32-TIME_W){1'b0}}, mute_fn};
        `REG_LIM_SPEED:   rd_mux = {{(32-SPEED_W){1'b0}}, lim_speed};
        `REG_MAX_SPEED:   rd_mux = {{(32-SPEED_W){1'b0}}, max_speed};
        `REG_BRAKE_SPEED: rd_mux = {{(32-SPEED_W){1'b0}}, brake_speed};
        `REG_BRAKE_DELAY: rd_mux = {{(32-TIME_W){1'b0}}, brake_delay};
        `REG_STOP_TIME:   rd_mux = {{(32-TIME_W){1'b0}}, stop_time};
        `REG_RAMP0:       rd_mux = {{(32-SPEED_W){1'b0}}, ramp0};
        `REG_RAMP1:       rd_mux = {{(32-SPEED_W){1'b0}}, ramp1};
        `REG_DIFF_LIMIT:  rd_mux = {{(32-SPEED_W){1'b0}}, diff_limit};
        `REG_STATUS:      rd_mux = {21'h0, state, 2'h0, failsafe, muted, in_estop,
                                    (state != ST_RUN), brake_output, torque_cutoff};
        default:          rd_mux = 32'h0000_0000;
        endcase
    end
    // Status is taken at address acceptance, not at data return
    wire rd_ok = (s_axi_araddr[7:0] <= `REG_DIFF_LIMIT) && (s_axi_araddr[1:0] == 2'h0);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// [core/stop_supervisor_defs.vh]
// Register offsets, fields, reset values and timing counts of the stop supervisor
`ifndef STOP_SUPERVISOR_DEFS_VH
`define STOP_SUPERVISOR_DEFS_VH
`define REG_CTRL        8'h00
`define REG_CFG         8'h04
`define REG_MUTE_GLOBAL 8'h08
`define REG_MUTE_FN     8'h0c
`define REG_LIM_SPEED   8'h10
`define REG_MAX_SPEED   8'h14
`define REG_BRAKE_SPEED 8'h18
`define REG_BRAKE_DELAY 8'h1c
`define REG_STOP_TIME   8'h20
`define REG_RAMP0       8'h24
`define REG_RAMP1       8'h28
`define REG_STATUS      8'h2c
`define REG_DIFF_LIMIT  8'h30
// Control bits, written as levels; CTRL_CLEAR drops back to 0 one cycle after its write
`define CTRL_TORQUE_CUT  0
`define CTRL_RAMP_STOP   1
`define CTRL_ESTOP       2
`define CTRL_LIM_SPEED   3
`define CTRL_RESTART_INH 4
`define CTRL_CLEAR       5
// Configuration bits
`define CFG_RAMP_STOP_TYPE 0
`define CFG_ESTOP_IMMED    1
`define CFG_ESTOP_TYPE     2
`define CFG_BRAKE_ORDER_LO 3
`define CFG_BRAKE_ORDER_HI 4
`define CFG_BRAKE_AT_SPEED 5
`define CFG_MAX_GUARD_EN   6
`define CFG_PER_FN_MUTE    7
`define CFG_ENCODER_SRC    8
`define CFG_RESET_VAL      9'h000
// Brake order codes
`define BRAKE_WITH   2'h0
`define BRAKE_BEFORE 2'h1
`define BRAKE_AFTER  2'h2
// Status bits
`define ST_TORQUE_CUT 0
`define ST_BRAKE      1
`define ST_RAMP_STOP  2
`define ST_ESTOP      3
`define ST_MUTED      4
`define ST_FAILSAFE   5
`define ST_STATE_LO   8
// Timing: brake-to-torque lag for brake-before / brake-after, microseconds
`define BRAKE_LAG_US  10
`define CLK_MHZ       20
`endif

// [sim/drive_model.sv]
// Drive and motor model behind the torque-off circuit and brake
`timescale 1ns/1ps
module drive_model (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        torque_cutoff,
    input  wire        brake_output,
    input  wire [15:0] target,
    output reg  [15:0] speed
);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            speed <= 16'h0000;
        end else if (torque_cutoff) begin
            // No torque: coast, faster with brake
            speed <= (speed > 16'h0004) ? speed - (brake_output ? 16'h0004 : 16'h0001) : 16'h0000;
        end else begin
            speed <= target;
        end
    end
endmodule

// [sim/safety_stop_supervisor_test.sv]
// Self-checking bench for the stop supervisor
`timescale 1ns/1ps
`include "stop_supervisor_defs.vh"
module safety_stop_supervisor_test;
    reg  [31:0] awaddr, wdata, araddr;
    reg         clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, fault;
    reg  [7:0]  scale;
    reg  [15:0] target, skew;
    reg  [31:0] rd;
    reg  [1:0]  rs;
    wire [31:0] rdata;
    wire [1:0]  bresp, rresp;
    wire [15:0] speed;
    wire        awready, wready, bvalid, arready, rvalid, cut, brake;
    integer     n_mismatch, checks, k;
    safety_stop_supervisor i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .speed_est(speed), .speed_drive(speed ^ skew), .speed_enc(speed), .lim_scale(scale),
        .internal_fault(fault), .torque_cutoff(cut), .brake_output(brake));
    drive_model i_drive (.clk_sys(clk_sys), .rst_n(rst_n), .torque_cutoff(cut),
        .brake_output(brake), .target(target), .speed(speed));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            awaddr <= {24'h0, a};
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            rs = 2'h3;
            while (rs === 2'h3) begin
                @(posedge clk_sys);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) rs = bresp;
            end
            bready <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rdr(input [7:0] a);
        begin
            araddr <= {24'h0, a};
            arvalid <= 1'b1;
            rready <= 1'b1;
            rs = 2'h3;
            while (rs === 2'h3) begin
                @(posedge clk_sys);
                if (arready) arvalid <= 1'b0;
                rd = rdata;
                if (rvalid) rs = rresp;
            end
            rready <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    // Bounded wait for one output (any) or both
    task wait_out(input both);
        begin
            k = 0;
            while ((both ? !(cut & brake) : !(cut | brake)) && k < 400) begin
                @(posedge clk_sys);
                k = k + 1;
            end
        end
    endtask
    // Guard off first, else the coasting speed trips again
    task clear_all;
        begin
            target <= 16'h0000;
            fault <= 1'b0;
            idle(8);
            wr(`REG_CFG, 32'h0);
            wr(`REG_CTRL, 32'h20);
            idle(210);
            cmp({cut, brake}, 2'h0);
        end
    endtask
    task t_regs;
        begin
            rdr(`REG_CFG);
            cmp(rd, `CFG_RESET_VAL);
            wr(`REG_BRAKE_DELAY, 32'h5);
            rdr(`REG_BRAKE_DELAY);
            cmp(rd, 32'h5);
            rdr(8'h40);
            cmp({rd[29:0], rs}, 32'h2);
            wr(`REG_STATUS, 32'h1);
            cmp(rs, 2'h2);
        end
    endtask
    task t_fault;
        begin
            wr(`REG_CFG, 32'h0);
            fault <= 1'b1;
            idle(6);
            cmp({cut, brake}, 2'h3);
            rdr(`REG_STATUS);
            cmp(rd[`ST_ESTOP], 1'b1);
            clear_all;
        end
    endtask
    task t_orders;
        integer o;
        begin
            for (o = 0; o < 3; o = o + 1) begin
                wr(`REG_CFG, o << 3);
                wr(`REG_CTRL, 32'h1);
                wait_out(1'b0);
                cmp({cut, brake}, o == 0 ? 2'h3 : o == 1 ? 2'h1 : 2'h2);
                wait_out(1'b1);
                cmp(k, o == 0 ? 0 : `BRAKE_LAG_US * `CLK_MHZ);
                clear_all;
            end
        end
    endtask
    task t_speed(input [31:0] cfg, ctl, lim, mg, mf, input [7:0] sc, input [15:0] tg, input integer lo, hi);
        begin
            wr(`REG_CFG, cfg);
            wr(`REG_MAX_SPEED, 32'd1000);
            wr(`REG_LIM_SPEED, lim);
            wr(`REG_MUTE_GLOBAL, mg);
            wr(`REG_MUTE_FN, mf);
            wr(`REG_CTRL, ctl);
            scale <= sc;
            idle(4);
            target <= tg;
            wait_out(1'b1);
            cmp(k >= lo && k <= hi, 1'b1);
            clear_all;
            scale <= 8'hff;
        end
    endtask
    task t_ramp;
        begin
            wr(`REG_CFG, 32'h20);
            wr(`REG_BRAKE_SPEED, 32'd300);
            wr(`REG_STOP_TIME, 32'd5000);
            target <= 16'd1000;
            idle(4);
            wr(`REG_CTRL, 32'h2);
            target <= 16'd250;
            wait_out(1'b0);
            cmp({cut, brake}, 2'h1);
            wait_out(1'b1);
            cmp(k, 5);
            clear_all;
            wr(`REG_CTRL, 32'h2);
            wait_out(1'b0);
            cmp({cut, brake}, 2'h1);
            wait_out(1'b1);
            cmp(k, 5);
            clear_all;
            wr(`REG_CFG, 32'h01);
            wr(`REG_RAMP1, 32'd10);
            target <= 16'd1000;
            idle(4);
            wr(`REG_CTRL, 32'h2);
            wait_out(1'b0);
            cmp({cut, brake}, 2'h3);
            clear_all;
        end
    endtask
    task wrap_up;
        begin
            if (n_mismatch == 0 && checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        #3000000;
        n_mismatch = n_mismatch + 1;
        wrap_up;
    end
    initial begin
        {awaddr, wdata, araddr, target, skew} = 0;
        {awvalid, wvalid, bready, arvalid, rready, fault} = 0;
        {rst_n, n_mismatch, checks} = 0;
        scale = 8'hff;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        idle(2);
        t_regs;
        t_fault;
        t_orders;
        t_speed(32'h42, 32'h0, 32'd0, 32'd0, 32'd0, 8'hff, 16'd2000, 1, 10);
        t_speed(32'h02, 32'h0, 32'd0, 32'd0, 32'd0, 8'hff, 16'd2000, 400, 400);
        t_speed(32'h02, 32'h8, 32'd500, 32'd40, 32'd0, 8'hff, 16'd1000, 40, 52);
        t_speed(32'h182, 32'h8, 32'd500, 32'd20, 32'd80, 8'hff, 16'd1000, 80, 92);
        t_speed(32'h02, 32'h8, 32'd1000, 32'd0, 32'd0, 8'h80, 16'd700, 1, 10);
        wr(`REG_CTRL, 32'h10);
        idle(4);
        cmp(cut, 1'b1);
        clear_all;
        t_ramp;
        wr(`REG_DIFF_LIMIT, 32'd50);
        skew <= 16'h0100;
        idle(6);
        cmp({cut, brake}, 2'h3);
        rdr(`REG_STATUS);
        cmp(rd[`ST_FAILSAFE], 1'b1);
        skew <= 16'h0000;
        wr(`REG_CTRL, 32'h20);
        clear_all;
        wrap_up;
    end
endmodule

// [sim/stop_sup_sva.sv]
// Port checker for the stop supervisor
`timescale 1ns/1ps
module stop_sup_sva (
    input wire clk_sys,
    input wire rst_n,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire internal_fault,
    input wire torque_cutoff,
    input wire brake_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_w_taken; s_axi_wvalid && s_axi_wready; endsequence
    sequence s_r_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_both_out; torque_cutoff && brake_output; endsequence
    // Two sync flops plus output register
    property p_fault_cut;
        $rose(internal_fault) |-> ##[1:6] (torque_cutoff || brake_output) ##[0:202] s_both_out;
    endproperty
    a_fault_cut: assert property (p_fault_cut) else $error("fault not followed by cut");
    property p_fault_hold; internal_fault [*6] |-> (torque_cutoff || brake_output); endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("cut or brake low in fault");
    property p_fault_stays; internal_fault && torque_cutoff |=> torque_cutoff; endproperty
    a_fault_stays: assert property (p_fault_stays) else $error("cut dropped in fault");
    property p_cut_release; $fell(torque_cutoff) |-> !$past(internal_fault, 3); endproperty
    a_cut_release: assert property (p_cut_release) else $error("cut released too soon");
    property p_brake_then_cut; $rose(brake_output) |-> ##[0:210] torque_cutoff; endproperty
    a_brake_then_cut: assert property (p_brake_then_cut) else $error("brake without cut");
    property p_w_resp; s_w_taken |-> ##[1:4] s_axi_bvalid; endproperty
    a_w_resp: assert property (p_w_resp) else $error("no write response");
    property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_r_resp; s_r_taken |-> ##[1:3] s_axi_rvalid; endproperty
    a_r_resp: assert property (p_r_resp) else $error("no read response");
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_once: assert property (p_r_once) else $error("read response repeated");
endmodule
bind safety_stop_supervisor stop_sup_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .internal_fault(internal_fault),
    .torque_cutoff(torque_cutoff), .brake_output(brake_output));
